// *** rtl/osc_consts.vh ***
// oscillator control block constants: register offsets, fields, reset values, timing
// assumes inclusion by bare name from the design files
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH
`define OSC_ADDR_CTRL 2'h0
`define OSC_ADDR_STAT 2'h1
`define OSC_ADDR_TUNE 2'h2
`define OSC_CTRL_PLL_BIT 7
`define OSC_CTRL_FSEL_HI 6
`define OSC_CTRL_FSEL_LO 3
`define OSC_CTRL_SCS_HI 1
`define OSC_CTRL_SCS_LO 0
`define OSC_CTRL_WMASK 8'hFB
`define OSC_TUNE_WMASK 8'h3F
`define OSC_CTRL_RESET 8'h38
`define OSC_TUNE_RESET 8'h00
`define OSC_TRIM_RESET 6'h00
`define OSC_FSEL_RESET 4'h7
`define OSC_STAT_T1_BIT 7
`define OSC_STAT_PLL_BIT 6
`define OSC_STAT_EXT_BIT 5
`define OSC_STAT_HFR_BIT 4
`define OSC_STAT_HFL_BIT 3
`define OSC_STAT_MFR_BIT 2
`define OSC_STAT_LFR_BIT 1
`define OSC_STAT_HFS_BIT 0
`define OSC_SRC_CFG 2'h0
`define OSC_SRC_SEC 2'h1
`define OSC_SRC_HF 2'h0
`define OSC_SRC_MF 2'h1
`define OSC_SRC_LF 2'h2
`define OSC_START_COUNT 11'h400
`endif

// *** rtl/osc_ctrl_regs.v ***
// oscillator control, status and tuning registers with clock source selection
// assumes analog ready/lock and external clock edge inputs are asynchronous
// Operation
// - pll force bit keeps pll enabled
// - otherwise software request bit drives pll
// - codes 1111..1011 select hf source
// - codes 1010,1001,1000,0011 duplicate from hf
// - mf codes; field resets to 0111
// - 000x selects lf oscillator
// - source field picks system clock
// - external active bit reports config source
// - secondary ready, forced 1 when disabled
// - pll ready status bit
// - hf, mf, lf ready bits
// - hf coarse lock at 2 percent
// - hf fine stable at half percent
// - signed six-bit trim passed to oscillator
// - crystal modes count 1024 before switching
// - writing a different source field value restarts start-up count
// - clock failure falls back to internal
`timescale 1ns/100ps
`include "osc_consts.vh"
module osc_ctrl_regs (
    input wire REF_CLK,
    input wire SRST,
    input wire [1:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    input wire CFG_PLL_FORCE,
    input wire [2:0] CFG_OSC_MODE,
    input wire SEC_OSC_ENABLE,
    input wire SEC_OSC_READY_IN,
    input wire PLL_LOCK_IN,
    input wire HF_READY_IN,
    input wire MF_READY_IN,
    input wire LF_READY_IN,
    input wire HF_COARSE_IN,
    input wire HF_FINE_IN,
    input wire EXT_CLK_IN,
    input wire CLK_FAIL_IN,
    output reg PLL_ENABLE,
    output reg [3:0] FREQ_SELECT,
    output reg [1:0] INT_SRC,
    output reg [5:0] FREQ_TRIM,
    output reg [1:0] SYSCLK_SRC,
    output reg USE_INTERNAL
);
    localparam ST_INT = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_EXT = 2'h2;
    reg [7:0] ctrl_reg;
    reg [5:0] tune_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [10:0] cnt_reg;
    reg [10:0] cnt_next;
    reg ext_prev_reg;
    reg fail_reg;
    reg [1:0] int_src_next;
    wire sec_rdy;
    wire pll_rdy;
    wire hf_rdy;
    wire mf_rdy;
    wire lf_rdy;
    wire hf_crs;
    wire hf_fin;
    wire ext_clk;
    wire clk_fail;
    wire [3:0] fsel;
    wire [1:0] scs;
    wire crystal_mode;
    wire ext_edge;
    wire scs_write;
    wire ext_active;
    wire [7:0] stat_val;
    osc_sync #(.RESET_VAL(1'b0)) u_sec (.clk(REF_CLK), .srst(SRST),
        .din(SEC_OSC_READY_IN), .dout(sec_rdy));
    osc_sync #(.RESET_VAL(1'b0)) u_pll (.clk(REF_CLK), .srst(SRST),
        .din(PLL_LOCK_IN), .dout(pll_rdy));
    osc_sync #(.RESET_VAL(1'b0)) u_hfr (.clk(REF_CLK), .srst(SRST),
        .din(HF_READY_IN), .dout(hf_rdy));
    osc_sync #(.RESET_VAL(1'b0)) u_mfr (.clk(REF_CLK), .srst(SRST),
        .din(MF_READY_IN), .dout(mf_rdy));
    osc_sync #(.RESET_VAL(1'b0)) u_lfr (.clk(REF_CLK), .srst(SRST),
        .din(LF_READY_IN), .dout(lf_rdy));
    osc_sync #(.RESET_VAL(1'b0)) u_hfl (.clk(REF_CLK), .srst(SRST),
        .din(HF_COARSE_IN), .dout(hf_crs));
    osc_sync #(.RESET_VAL(1'b0)) u_hfs (.clk(REF_CLK), .srst(SRST),
        .din(HF_FINE_IN), .dout(hf_fin));
    osc_sync #(.RESET_VAL(1'b0)) u_ext (.clk(REF_CLK), .srst(SRST),
        .din(EXT_CLK_IN), .dout(ext_clk));
    osc_sync #(.RESET_VAL(1'b0)) u_cfm (.clk(REF_CLK), .srst(SRST),
        .din(CLK_FAIL_IN), .dout(clk_fail));
    assign fsel = ctrl_reg[`OSC_CTRL_FSEL_HI:`OSC_CTRL_FSEL_LO];
    assign scs = ctrl_reg[`OSC_CTRL_SCS_HI:`OSC_CTRL_SCS_LO];
    // lp, xt and hs modes are codes 0..2 and need start-up counting
    assign crystal_mode = (CFG_OSC_MODE < 3'h3);
    assign ext_edge = ext_clk & ~ext_prev_reg;
    assign scs_write = WR && (ADDR == `OSC_ADDR_CTRL) &&
        (WDATA[`OSC_CTRL_SCS_HI:`OSC_CTRL_SCS_LO] != scs);
    assign ext_active = (state_reg == ST_EXT);
    assign stat_val = {
        (SEC_OSC_ENABLE ? sec_rdy : 1'b1),
        pll_rdy,
        ext_active,
        hf_rdy,
        hf_crs,
        mf_rdy,
        lf_rdy,
        hf_fin
    };
    // register writes; status register has no write path
    always @(posedge REF_CLK) begin
        if (SRST) begin
            ctrl_reg <= `OSC_CTRL_RESET;
            tune_reg <= `OSC_TRIM_RESET;
        end else if (WR) begin
            if (ADDR == `OSC_ADDR_CTRL) begin
                ctrl_reg <= WDATA & `OSC_CTRL_WMASK;
            end else if (ADDR == `OSC_ADDR_TUNE) begin
                tune_reg <= WDATA[5:0];
            end
        end
    end
    // read data one cycle after the strobe, zero otherwise
    always @(posedge REF_CLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                `OSC_ADDR_CTRL: RDATA <= ctrl_reg;
                `OSC_ADDR_STAT: RDATA <= stat_val;
                `OSC_ADDR_TUNE: RDATA <= {2'h0, tune_reg};
                default: RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end
    // internal source decode for the frequency field
    always @* begin
        int_src_next = `OSC_SRC_HF;
        if (fsel[3]) begin
            int_src_next = `OSC_SRC_HF;
        end else if (fsel[3:1] == 3'h0) begin
            int_src_next = `OSC_SRC_LF;
        end else if (fsel == 4'h3) begin
            int_src_next = `OSC_SRC_HF;
        end else begin
            int_src_next = `OSC_SRC_MF;
        end
    end
    // start-up and fallback sequencing
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_INT: begin
                if (scs == `OSC_SRC_CFG && !fail_reg) begin
                    cnt_next = 11'h000;
                    state_next = crystal_mode ? ST_WAIT : ST_EXT;
                end
            end
            ST_WAIT: begin
                if (ext_edge) begin
                    cnt_next = cnt_reg + 11'h001;
                end
                if (cnt_reg == `OSC_START_COUNT) begin
                    state_next = ST_EXT;
                end
            end
            ST_EXT: begin
                if (clk_fail) begin
                    state_next = ST_INT;
                end
            end
            default: state_next = ST_INT;
        endcase
        if (scs_write) begin
            cnt_next = 11'h000;
            state_next = ST_INT;
        end else if (scs != `OSC_SRC_CFG) begin
            state_next = ST_INT;
        end
    end
    always @(posedge REF_CLK) begin
        if (SRST) begin
            state_reg <= ST_INT;
            cnt_reg <= 11'h000;
            ext_prev_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ext_prev_reg <= ext_clk;
            if (scs_write) begin
                fail_reg <= 1'b0;
            end else if (state_reg == ST_EXT && clk_fail) begin
                fail_reg <= 1'b1;
            end
        end
    end
    // oscillator control outputs, registered from the stored fields, the pll force input and the sequencer state
    always @(posedge REF_CLK) begin
        if (SRST) begin
            PLL_ENABLE <= 1'b0;
            FREQ_SELECT <= `OSC_FSEL_RESET;
            INT_SRC <= `OSC_SRC_MF;
            FREQ_TRIM <= `OSC_TRIM_RESET;
            SYSCLK_SRC <= 2'h2;
            USE_INTERNAL <= 1'b1;
        end else begin
            PLL_ENABLE <= CFG_PLL_FORCE | ctrl_reg[`OSC_CTRL_PLL_BIT];
            FREQ_SELECT <= fsel;
            INT_SRC <= int_src_next;
            FREQ_TRIM <= tune_reg;
            if (scs[1]) begin
                SYSCLK_SRC <= 2'h2;
            end else begin
                SYSCLK_SRC <= scs;
            end
            USE_INTERNAL <= (scs[1] || (scs == `OSC_SRC_CFG && !ext_active));
        end
    end
endmodule

// *** rtl/osc_sync.v ***
// three-flop synchroniser with agreement filter for one asynchronous level
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/100ps
module osc_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk,
    input wire srst,
    input wire din,
    output reg dout
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge clk) begin
        if (srst) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule

// *** sim/osc_ctrl_regs_monitor.sv ***
// assertion checker for the oscillator control registers
// assumes a bind onto osc_ctrl_regs, one clock, sync reset
`timescale 1ns/100ps
module osc_ctrl_regs_monitor (
    input logic REF_CLK,
    input logic SRST,
    input logic [1:0] ADDR,
    input logic [7:0] WDATA,
    input logic WR,
    input logic RD,
    input logic [7:0] RDATA,
    input logic CFG_PLL_FORCE,
    input logic SEC_OSC_ENABLE,
    input logic PLL_ENABLE,
    input logic [3:0] FREQ_SELECT,
    input logic [1:0] INT_SRC,
    input logic [5:0] FREQ_TRIM,
    input logic [1:0] SYSCLK_SRC
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    function automatic logic [1:0] src_of(input logic [3:0] f);
        if (f[3] || f == 4'h3) return 2'h0;
        if (f[3:1] == 3'h0) return 2'h2;
        return 2'h1;
    endfunction
    pll_request_a: assert property (WR && ADDR == 2'h0 && !CFG_PLL_FORCE |->
        ##2 (PLL_ENABLE == $past(WDATA[7], 2) || CFG_PLL_FORCE)) else $error("pll request");
    freq_select_a: assert property (WR && ADDR == 2'h0 |->
        ##2 FREQ_SELECT == $past(WDATA[6:3], 2)) else $error("freq select");
    trim_update_a: assert property (WR && ADDR == 2'h2 |->
        ##2 FREQ_TRIM == $past(WDATA[5:0], 2)) else $error("trim");
    src_map_a: assert property ($stable(FREQ_SELECT) |-> INT_SRC == src_of(FREQ_SELECT))
        else $error("source map");
    sysclk_sel_a: assert property (WR && ADDR == 2'h0 |-> ##2 SYSCLK_SRC ==
        ($past(WDATA[1], 2) ? 2'h2 : $past(WDATA[1:0], 2))) else $error("sysclk select");
    read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata idle");
    ctrl_gap_a: assert property ($past(RD) && $past(ADDR) == 2'h0 |-> !RDATA[2])
        else $error("ctrl bit2");
    sec_ready_a: assert property ($past(RD) && $past(ADDR) == 2'h1 &&
        !$past(SEC_OSC_ENABLE) |-> RDATA[7]) else $error("secondary ready");
endmodule

// *** sim/osc_ctrl_regs_test.sv ***
// self-checking bench for the oscillator control registers
// assumes osc_ctrl_regs and its monitor are compiled first
`timescale 1ns/100ps
module osc_ctrl_regs_test;
    logic clk, srst, wr, rd, force_pll, sen, srdy, lock, hfr, mfr, lfr, crs, fin, ext, fail;
    logic [1:0] addr;
    logic [2:0] osc_mode;
    logic [7:0] wdata;
    wire [7:0] rdata;
    wire pll, use_int;
    wire [3:0] fsel;
    wire [1:0] isrc, ssrc;
    wire [5:0] trim;
    int mismatches = 0;
    int checked = 0;
    logic [1:0] src_tab [16] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    osc_ctrl_regs u_osc_ctrl_regs (.REF_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .CFG_PLL_FORCE(force_pll), .CFG_OSC_MODE(osc_mode),
        .SEC_OSC_ENABLE(sen), .SEC_OSC_READY_IN(srdy), .PLL_LOCK_IN(lock),
        .HF_READY_IN(hfr), .MF_READY_IN(mfr), .LF_READY_IN(lfr), .HF_COARSE_IN(crs),
        .HF_FINE_IN(fin), .EXT_CLK_IN(ext), .CLK_FAIL_IN(fail), .PLL_ENABLE(pll),
        .FREQ_SELECT(fsel), .INT_SRC(isrc), .FREQ_TRIM(trim), .SYSCLK_SRC(ssrc),
        .USE_INTERNAL(use_int));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic ext_edges(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            ext <= 1'b1;
            repeat (4) @(posedge clk);
            ext <= 1'b0;
        end
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        {srst, wr, rd, addr, wdata, force_pll, sen, srdy, ext, fail} = 18'h20000;
        osc_mode = 3'h0;
        {lock, hfr, mfr, lfr, crs, fin} = 6'b110110;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        wait_n(1);
        chk({pll, fsel, isrc, use_int}, {1'b0, 4'h7, 2'h1, 1'b1});
        chk({trim, ssrc}, {6'h00, 2'h0});
        rd_reg(2'h0, 8'h38);
        for (int i = 0; i < 16; i++) begin
            wr_reg(2'h0, {1'b0, i[3:0], 3'h7});
            wait_n(3);
            chk({fsel, ssrc, isrc}, {i[3:0], 2'h2, src_tab[i]});
            rd_reg(2'h0, {1'b0, i[3:0], 3'h3});
        end
        wr_reg(2'h0, 8'hFB);
        wait_n(3);
        chk({7'h0, pll}, 8'h01);
        wr_reg(2'h0, 8'h7B);
        wait_n(3);
        chk({7'h0, pll}, 8'h00);
        force_pll <= 1'b1;
        wait_n(3);
        chk({7'h0, pll}, 8'h01);
        force_pll <= 1'b0;
        wr_reg(2'h2, 8'hE0);
        wait_n(3);
        chk({2'h0, trim}, 8'h20);
        wr_reg(2'h2, 8'h5F);
        rd_reg(2'h2, 8'h1F);
        rd_reg(2'h1, 8'hDA);
        {sen, lock, hfr, mfr, lfr, crs, fin} <= 7'b1001001;
        wr_reg(2'h1, 8'hFF);
        wr_reg(2'h3, 8'hFF);
        rd_reg(2'h3, 8'h00);
        wait_n(8);
        rd_reg(2'h1, 8'h05);
        wr_reg(2'h0, 8'h78);
        ext_edges(1023);
        wait_n(10);
        chk({5'h0, ssrc, use_int}, 8'h01);
        ext_edges(1);
        wait_n(10);
        chk({5'h0, ssrc, use_int}, 8'h00);
        rd_reg(2'h1, 8'h25);
        fail <= 1'b1;
        wait_n(10);
        chk({fsel, 3'h0, use_int}, 8'hF1);
        fail <= 1'b0;
        wr_reg(2'h0, 8'h7B);
        wr_reg(2'h0, 8'h78);
        wait_n(20);
        chk({7'h0, use_int}, 8'h01);
        osc_mode <= 3'h4;
        wr_reg(2'h0, 8'h7B);
        wr_reg(2'h0, 8'h78);
        wait_n(5);
        chk({7'h0, use_int}, 8'h00);
        rd_reg(2'h1, 8'h25);
        results();
    end
endmodule
bind osc_ctrl_regs osc_ctrl_regs_monitor u_osc_ctrl_regs_monitor (.REF_CLK(REF_CLK),
    .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CFG_PLL_FORCE(CFG_PLL_FORCE), .SEC_OSC_ENABLE(SEC_OSC_ENABLE), .PLL_ENABLE(PLL_ENABLE),
    .FREQ_SELECT(FREQ_SELECT), .INT_SRC(INT_SRC), .FREQ_TRIM(FREQ_TRIM),
    .SYSCLK_SRC(SYSCLK_SRC));
